//--- common/cabe_pkg.sv
// Purpose: shared constants and types of the execute stage (alu, multiply, flow control)
// Assumes: one 100 MHz core clock, operands already read from the register file
// Notes:   status register bit positions follow the usual I T H S V N Z C order
package cabe_pkg;

  // status register bit positions
  localparam int SREG_C = 0;  // carry
  localparam int SREG_Z = 1;  // zero
  localparam int SREG_N = 2;  // negative
  localparam int SREG_V = 3;  // two's complement overflow
  localparam int SREG_S = 4;  // sign, n xor v
  localparam int SREG_H = 5;  // half carry
  localparam int SREG_I = 7;  // global interrupt enable

  localparam int PC_W = 22;  // program counter width in bits, counting words

  // execution lengths in core clock cycles
  localparam logic [2:0] CYC_ONE   = 3'h1;  // register and single operand ops
  localparam logic [2:0] CYC_WORD  = 3'h2;  // word add and subtract immediate
  localparam logic [2:0] CYC_MUL   = 3'h2;  // all multiplies
  localparam logic [2:0] CYC_RELATIVE_JUMP  = 3'h2;  // relative and indirect jump
  localparam logic [2:0] CYC_DJMP  = 3'h3;  // direct jump
  localparam logic [2:0] CYC_RELATIVE_SUBROUTINE_INVOKE = 3'h4;  // relative and indirect call
  localparam logic [2:0] CYC_DCALL = 3'h5;  // direct call
  localparam logic [2:0] CYC_RET   = 3'h5;  // subroutine and interrupt exit
  localparam logic [2:0] CYC_SKIP1 = 3'h2;  // skip over a one word instruction
  localparam logic [2:0] CYC_SKIP2 = 3'h3;  // skip over a two word instruction

  // program counter steps
  localparam logic [PC_W-1:0] PC_STEP1 = 22'h00_0001;
  localparam logic [PC_W-1:0] PC_STEP2 = 22'h00_0002;
  localparam logic [PC_W-1:0] PC_STEP3 = 22'h00_0003;

  // decoded operation presented by the decoder
  typedef enum logic [5:0] {
    op_nop, op_add, op_add_carry, op_word_add_immediate, op_subtract,
    op_subtract_constant, op_subtract_borrow, op_subtract_borrow_constant,
    op_word_subtract_immediate, op_and, op_mask_constant, op_or, op_merge_constant,
    op_xor_registers, op_bitwise_invert, op_twos_complement_op, op_bits_set,
    op_bits_clear, op_plus_one, op_minus_one, op_test_value, op_zero_register,
    op_set_all_ones, op_product_unsigned, op_product_signed,
    op_product_signed_by_unsigned, op_fractional_product_unsigned,
    op_fractional_product_signed, op_fractional_product_mixed, op_relative_jump,
    op_indirect_jump, op_direct_jump, op_relative_subroutine_invoke,
    op_indirect_subroutine_invoke, op_direct_subroutine_invoke, op_subroutine_exit,
    op_interrupt_exit, op_compare_skip_equal
  } cabe_op_t;

  // whole state of the execute stage
  typedef struct packed {
    logic [2:0]      cnt;      // cycles still to run before done
    logic            done;     // result cycle
    logic            rd_we;    // write low destination
    logic [7:0]      res;      // low result byte
    logic            hi_we;    // write high register of a word pair
    logic [7:0]      res_hi;   // high result byte
    logic            prod_we;  // write product to r1:r0
    logic            sreg_we;  // status register update
    logic [7:0]      sreg;     // new status register
    logic            pc_we;    // program counter load
    logic [PC_W-1:0] pc;       // new program counter
    logic            push_we;  // push return address
    logic [PC_W-1:0] push_pc;  // return address
  } cabe_state_t;

endpackage

//--- src/cabe_exec.sv
// Purpose: execute stage for arithmetic, logic, multiply and flow control instructions
// Assumes: decoder gives operation and operands; register file and stack live outside
// Notes:   results and strobes appear together in the done cycle
//
// Functional notes
// - add and add-carry: sum, z c n v h, one cycle
// - word add immediate: pair sum, z c n v s, two cycles
// - subtract, subtract constant: z c n v h, one cycle
// - borrow subtracts also remove carry, one cycle
// - word subtract immediate: z c n v s, two cycles
// - and, mask constant: z n v only, one cycle
// - or, merge constant, xor: z n v, one cycle
// - single operand ops, listed flags, one cycle
// - bits set or, bits clear and-not, z n v
// - multiplies write r1:r0, z c, two cycles
// - fractional multiplies shift product left once first
// - relative/indirect jump two cycles, direct three
// - calls four or five, returns five cycles
// - compare skip: no flags, skip two or three
`timescale 1ns/1ps
module cabe_exec
  import cabe_pkg::*;
(
  input  wire logic            core_clk,     // core clock, 100 MHz
  input  wire logic            reset_n,      // asynchronous reset, active low
  input  wire cabe_op_t        issue_op,     // decoded operation
  input  wire logic            issue_valid,  // operation offered this cycle
  output logic                 issue_ready,  // stage can take an operation
  input  wire logic [7:0]      rd_val,       // destination (or low pair) operand
  input  wire logic [7:0]      rd_hi_val,    // high register of a word pair
  input  wire logic [7:0]      rr_val,       // source register operand
  input  wire logic [7:0]      imm_k,        // constant operand
  input  wire logic [11:0]     rel_k,        // signed relative offset
  input  wire logic [PC_W-1:0] abs_k,        // absolute target address
  input  wire logic [15:0]     z_ptr,        // z pointer for indirect jumps
  input  wire logic [PC_W-1:0] pc_in,        // address of this instruction
  input  wire logic [PC_W-1:0] stack_pc,     // return address popped from stack
  input  wire logic            next_long,    // following instruction is two words
  input  wire logic [7:0]      sreg_in,      // current status register
  output logic                 done,         // one-cycle result pulse
  output logic                 rd_we,        // write rd_data to destination
  output logic [7:0]           rd_data,      // low result byte
  output logic                 rd_hi_we,     // write rd_hi_data to high pair register
  output logic [7:0]           rd_hi_data,   // high result byte
  output logic                 r1r0_we,      // write r1r0_data to r1:r0
  output logic [15:0]          r1r0_data,    // product
  output logic                 sreg_we,      // load sreg_data into status register
  output logic [7:0]           sreg_data,    // new status register
  output logic                 pc_we,        // load pc_data into program counter
  output logic [PC_W-1:0]      pc_data,      // new program counter
  output logic                 push_we,      // push push_data onto return stack
  output logic [PC_W-1:0]      push_data     // return address
);

  cabe_state_t st_reg;   // registered state
  cabe_state_t st_next;  // next state
  logic        busy;     // multi-cycle operation in flight
  logic        fire;     // operation taken this cycle

  // flags of an 8-bit add
  function automatic logic [7:0] add_fl(input logic [7:0] s, a, b, r);
    logic [7:0] f;
    f = s;
    f[SREG_H] = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
    f[SREG_V] = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
    f[SREG_C] = (a[7] & b[7]) | (b[7] & ~r[7]) | (~r[7] & a[7]);
    f[SREG_N] = r[7];
    f[SREG_Z] = (r == 8'h00);
    return f;
  endfunction

  // flags of an 8-bit subtract a - b
  function automatic logic [7:0] sub_fl(input logic [7:0] s, a, b, r);
    logic [7:0] f;
    f = s;
    f[SREG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
    f[SREG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    f[SREG_C] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
    f[SREG_N] = r[7];
    f[SREG_Z] = (r == 8'h00);
    return f;
  endfunction

  // flags of a logic result: overflow always cleared
  function automatic logic [7:0] log_fl(input logic [7:0] s, r);
    logic [7:0] f;
    f = s;
    f[SREG_V] = 1'b0;
    f[SREG_N] = r[7];
    f[SREG_Z] = (r == 8'h00);
    return f;
  endfunction

  // a new operation is only taken when nothing is running
  assign busy        = (st_reg.cnt != 3'h0);
  assign issue_ready = ~busy;
  assign fire        = issue_valid & ~busy;

  // strobes qualified by the done cycle, data straight from flops
  assign done       = st_reg.done;
  assign rd_we      = st_reg.done & st_reg.rd_we;
  assign rd_hi_we   = st_reg.done & st_reg.hi_we;
  assign r1r0_we    = st_reg.done & st_reg.prod_we;
  assign sreg_we    = st_reg.done & st_reg.sreg_we;
  assign pc_we      = st_reg.done & st_reg.pc_we;
  assign push_we    = st_reg.done & st_reg.push_we;
  assign rd_data    = st_reg.res;
  assign rd_hi_data = st_reg.res_hi;
  assign r1r0_data  = {st_reg.res_hi, st_reg.res};
  assign sreg_data  = st_reg.sreg;
  assign pc_data    = st_reg.pc;
  assign push_data  = st_reg.push_pc;

  // next-state logic: result is computed at issue and held until done
  always_comb begin
    logic [7:0]      a;     // destination operand
    logic [7:0]      b;     // second operand, register or constant
    logic [7:0]      r;     // byte result
    logic [7:0]      f;     // new flags
    logic [15:0]     w;     // word pair operand
    logic [15:0]     wr;    // word result
    logic [15:0]     ea;    // multiplicand, extended
    logic [15:0]     eb;    // multiplier, extended
    logic [15:0]     p;     // raw product
    logic [15:0]     pr;    // product as written
    logic [2:0]      cyc;   // execution length
    logic [PC_W-1:0] rel;   // relative jump target
    a       = rd_val;
    b       = rr_val;
    r       = 8'h00;
    f       = sreg_in;
    w       = {rd_hi_val, rd_val};
    wr      = 16'h0000;
    ea      = {8'h00, rd_val};
    eb      = {8'h00, rr_val};
    p       = 16'h0000;
    pr      = 16'h0000;
    cyc     = CYC_ONE;
    rel     = pc_in + {{(PC_W-12){rel_k[11]}}, rel_k} + PC_STEP1;
    st_next = st_reg;
    if (busy) begin
      // count down; done fires as the count reaches zero
      st_next.cnt  = st_reg.cnt - 3'h1;
      st_next.done = (st_reg.cnt == 3'h1);
    end else if (fire) begin
      st_next.rd_we   = 1'b0;
      st_next.hi_we   = 1'b0;
      st_next.prod_we = 1'b0;
      st_next.sreg_we = 1'b1;
      st_next.pc_we   = 1'b0;
      st_next.push_we = 1'b0;
      case (issue_op)
        op_add, op_add_carry: begin
          r = a + b + {7'h00, (issue_op == op_add_carry) & sreg_in[SREG_C]};
          f = add_fl(sreg_in, a, b, r);
          st_next.rd_we = 1'b1;
        end
        op_subtract, op_subtract_constant, op_subtract_borrow,
        op_subtract_borrow_constant: begin
          if (issue_op == op_subtract_constant || issue_op == op_subtract_borrow_constant) begin
            b = imm_k;
          end
          if (issue_op == op_subtract_borrow || issue_op == op_subtract_borrow_constant) begin
            r = a - b - {7'h00, sreg_in[SREG_C]};
          end else begin
            r = a - b;
          end
          f = sub_fl(sreg_in, a, b, r);
          st_next.rd_we = 1'b1;
        end
        op_word_add_immediate: begin
          wr        = w + {8'h00, imm_k};
          f[SREG_V] = ~w[15] & wr[15];
          f[SREG_C] = w[15] & ~wr[15];
          cyc       = CYC_WORD;
        end
        op_word_subtract_immediate: begin
          wr        = w - {8'h00, imm_k};
          f[SREG_V] = w[15] & ~wr[15];
          f[SREG_C] = ~w[15] & wr[15];
          cyc       = CYC_WORD;
        end
        op_and, op_mask_constant, op_or, op_merge_constant, op_xor_registers,
        op_bits_set, op_bits_clear: begin
          if (issue_op == op_mask_constant || issue_op == op_merge_constant ||
              issue_op == op_bits_set) begin
            b = imm_k;
          end else if (issue_op == op_bits_clear) begin
            b = 8'hFF - imm_k;
          end
          if (issue_op == op_and || issue_op == op_mask_constant ||
              issue_op == op_bits_clear) begin
            r = a & b;
          end else if (issue_op == op_xor_registers) begin
            r = a ^ b;
          end else begin
            r = a | b;
          end
          f = log_fl(sreg_in, r);
          st_next.rd_we = 1'b1;
        end
        op_bitwise_invert: begin
          r         = 8'hFF - a;
          f         = log_fl(sreg_in, r);
          f[SREG_C] = 1'b1;
          st_next.rd_we = 1'b1;
        end
        op_twos_complement_op: begin
          r = 8'h00 - a;
          f = sub_fl(sreg_in, 8'h00, a, r);
          st_next.rd_we = 1'b1;
        end
        op_plus_one, op_minus_one: begin
          r = (issue_op == op_plus_one) ? a + 8'h01 : a - 8'h01;
          f = log_fl(sreg_in, r);
          f[SREG_V] = (issue_op == op_plus_one) ? (r == 8'h80) : (r == 8'h7F);
          st_next.rd_we = 1'b1;
        end
        op_test_value, op_zero_register: begin
          r = (issue_op == op_test_value) ? a : 8'h00;
          f = log_fl(sreg_in, r);
          // a test leaves the register alone; writing it back would be harmless anyway
          st_next.rd_we = (issue_op == op_zero_register);
        end
        op_set_all_ones: begin
          r = 8'hFF;
          st_next.rd_we   = 1'b1;
          st_next.sreg_we = 1'b0;
        end
        op_product_unsigned, op_product_signed, op_product_signed_by_unsigned,
        op_fractional_product_unsigned, op_fractional_product_signed,
        op_fractional_product_mixed: begin
          // sign extension then a 16x16 product keeps only the low word, which is exact
          if (issue_op != op_product_unsigned && issue_op != op_fractional_product_unsigned) begin
            ea = {{8{rd_val[7]}}, rd_val};
          end
          if (issue_op == op_product_signed || issue_op == op_fractional_product_signed) begin
            eb = {{8{rr_val[7]}}, rr_val};
          end
          p  = ea * eb;
          pr = (issue_op == op_product_unsigned || issue_op == op_product_signed ||
                issue_op == op_product_signed_by_unsigned) ? p : {p[14:0], 1'b0};
          f[SREG_C] = p[15];
          f[SREG_Z] = (pr == 16'h0000);
          st_next.prod_we = 1'b1;
          cyc = CYC_MUL;
        end
        op_relative_jump, op_indirect_jump, op_direct_jump: begin
          st_next.sreg_we = 1'b0;
          st_next.pc_we   = 1'b1;
          if (issue_op == op_relative_jump) begin
            st_next.pc = rel;
            cyc = CYC_RELATIVE_JUMP;
          end else if (issue_op == op_indirect_jump) begin
            st_next.pc = {6'h00, z_ptr};
            cyc = CYC_RELATIVE_JUMP;
          end else begin
            st_next.pc = abs_k;
            cyc = CYC_DJMP;
          end
        end
        op_relative_subroutine_invoke, op_indirect_subroutine_invoke,
        op_direct_subroutine_invoke: begin
          st_next.sreg_we = 1'b0;
          st_next.pc_we   = 1'b1;
          st_next.push_we = 1'b1;
          if (issue_op == op_relative_subroutine_invoke) begin
            st_next.pc      = rel;
            st_next.push_pc = pc_in + PC_STEP1;
            cyc = CYC_RELATIVE_SUBROUTINE_INVOKE;
          end else if (issue_op == op_indirect_subroutine_invoke) begin
            st_next.pc      = {6'h00, z_ptr};
            st_next.push_pc = pc_in + PC_STEP1;
            cyc = CYC_RELATIVE_SUBROUTINE_INVOKE;
          end else begin
            // a direct call is two words long, so it returns two words on
            st_next.pc      = abs_k;
            st_next.push_pc = pc_in + PC_STEP2;
            cyc = CYC_DCALL;
          end
        end
        op_subroutine_exit, op_interrupt_exit: begin
          st_next.pc      = stack_pc;
          st_next.pc_we   = 1'b1;
          f[SREG_I]       = 1'b1;
          st_next.sreg_we = (issue_op == op_interrupt_exit);
          cyc = CYC_RET;
        end
        op_compare_skip_equal: begin
          // flags untouched; not equal simply lets the fetch unit go on
          st_next.sreg_we = 1'b0;
          if (rd_val == rr_val) begin
            st_next.pc_we = 1'b1;
            st_next.pc    = pc_in + (next_long ? PC_STEP3 : PC_STEP2);
            cyc = next_long ? CYC_SKIP2 : CYC_SKIP1;
          end
        end
        default: begin
          st_next.sreg_we = 1'b0;  // no operation
        end
      endcase
      if (issue_op == op_word_add_immediate || issue_op == op_word_subtract_immediate) begin
        f[SREG_N] = wr[15];
        f[SREG_Z] = (wr == 16'h0000);
        f[SREG_S] = wr[15] ^ f[SREG_V];
        r = wr[7:0];
        st_next.res_hi = wr[15:8];
        st_next.rd_we  = 1'b1;
        st_next.hi_we  = 1'b1;
      end else if (st_next.prod_we) begin
        r = pr[7:0];
        st_next.res_hi = pr[15:8];
      end
      st_next.res  = r;
      st_next.sreg = f;  // unlisted flags pass through from sreg_in
      st_next.cnt  = cyc - 3'h1;
      st_next.done = (cyc == CYC_ONE);
    end else begin
      st_next.done = 1'b0;
    end
  end

  // single state register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  chk_add_one_cycle: assert property (fire && issue_op == op_add |=> done && rd_we &&
    rd_data == 8'($past(rd_val) + $past(rr_val))) else $error("add result or timing wrong");
  chk_word_add_two: assert property (fire && issue_op == op_word_add_immediate |=>
    !done ##1 (done && rd_hi_we && {rd_hi_data, rd_data} ==
    16'({$past(rd_hi_val, 2), $past(rd_val, 2)} + {8'h00, $past(imm_k, 2)})))
    else $error("word add wrong");
  chk_sub_carry: assert property (fire && issue_op == op_subtract |=>
    sreg_data[SREG_C] == ($past(rr_val) > $past(rd_val))) else $error("subtract carry wrong");
  chk_and_flags: assert property (fire && issue_op == op_and |=> !sreg_data[SREG_V] &&
    sreg_data[SREG_C] == $past(sreg_in[SREG_C])) else $error("logic flags wrong");
  chk_ones_noflags: assert property (fire && issue_op == op_set_all_ones |=>
    rd_data == 8'hFF && !sreg_we) else $error("set all ones wrong");
  chk_mul_product: assert property (fire && issue_op == op_product_unsigned |-> ##2
    (r1r0_we && r1r0_data == 16'($past(rd_val, 2) * $past(rr_val, 2))))
    else $error("unsigned product wrong");
  chk_frac_shift: assert property (fire && issue_op == op_fractional_product_unsigned |->
    ##2 (r1r0_we && r1r0_data[0] == 1'b0)) else $error("fractional shift missing");
  chk_direct_jump: assert property (fire && issue_op == op_direct_jump |=>
    !done[*2] ##1 (pc_we && pc_data == $past(abs_k, 3))) else $error("direct jump wrong");
  chk_call_five: assert property (fire && issue_op == op_direct_subroutine_invoke |=>
    !done[*4] ##1 (push_we && pc_we)) else $error("direct call timing wrong");
  chk_interrupt_exit_enable: assert property (fire && issue_op == op_interrupt_exit |-> ##5
    (sreg_we && sreg_data[SREG_I])) else $error("interrupt exit enable missing");
  chk_skip_equal: assert property (fire && issue_op == op_compare_skip_equal &&
    rd_val == rr_val && !next_long |=> !done ##1 (done && !sreg_we &&
    pc_data == $past(pc_in, 2) + PC_STEP2)) else $error("compare skip wrong");
  chk_word_sign: assert property (sreg_we && st_reg.hi_we |->
    sreg_data[SREG_S] == (rd_hi_data[7] ^ sreg_data[SREG_V])) else $error("sign flag wrong");

  cov_add_carry: cover property (fire && issue_op == op_add_carry && sreg_in[SREG_C]);
  cov_signed_mul: cover property (fire && issue_op == op_product_signed ##2 done);
  cov_long_skip: cover property (fire && issue_op == op_compare_skip_equal && next_long);
  cov_back_to_back: cover property (fire ##1 fire);

endmodule

//--- tb/cabe_fetch_model.sv
// Purpose: fetch unit and register file stand-in on the far side of the execute stage
// Assumes: one clock; write and push strobes last one cycle
// Notes:   a one-deep return stack is enough for the call-then-exit order used
`timescale 1ns/1ps
module cabe_fetch_model
  import cabe_pkg::*;
(
  input  wire logic            core_clk,   // core clock
  input  wire logic            reset_n,    // asynchronous reset, active low
  input  wire logic            r1r0_we,    // product write strobe
  input  wire logic [15:0]     r1r0_data,  // product
  input  wire logic            push_we,    // return address push strobe
  input  wire logic [PC_W-1:0] push_data,  // pushed return address
  output logic      [15:0]     r1r0_reg,   // stored r1:r0 pair
  output logic      [PC_W-1:0] stack_top   // top of stack, feeds the popped address
);
  // the pair and the stack slot change only on their strobes, like the real file
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      r1r0_reg  <= 16'h0000;
      stack_top <= 22'h00_0000;
    end else begin
      if (r1r0_we) begin
        r1r0_reg <= r1r0_data;
      end
      if (push_we) begin
        stack_top <= push_data;
      end
    end
  end
endmodule

//--- tb/tb_top.sv
// Purpose: self-checking bench of the execute stage
// Assumes: one op in flight; operands held only until the op is taken
// Notes:   status results are judged as sreg_in when no status write is made
`timescale 1ns/1ps
module tb_top
  import cabe_pkg::*;
;
  logic            core_clk = 1'b0, reset_n = 1'b0, issue_valid = 1'b0, next_long = 1'b0;
  cabe_op_t        issue_op = op_nop;                     // offered operation
  logic [7:0]      rd_val = 8'h00, rd_hi_val = 8'h00, rr_val = 8'h00, imm_k = 8'h00;
  logic [7:0]      sreg_in = 8'h00;                       // status before the op
  logic [11:0]     rel_k = 12'hFFE;                       // offset of minus two
  logic [PC_W-1:0] abs_k = 22'h3F_0000, pc_in = 22'h00_0100;
  logic [15:0]     z_ptr = 16'h1234;                      // indirect target
  logic            issue_ready, done, rd_we, rd_hi_we, r1r0_we, sreg_we, pc_we, push_we;
  logic [7:0]      rd_data, rd_hi_data, sreg_data;
  logic [15:0]     r1r0_data, m_r1r0;
  logic [PC_W-1:0] pc_data, push_data, stack_pc;
  int              num_errors = 0, checks_done = 0;
  cabe_exec i_dut (.core_clk, .reset_n, .issue_op, .issue_valid, .issue_ready, .rd_val,
    .rd_hi_val, .rr_val, .imm_k, .rel_k, .abs_k, .z_ptr, .pc_in, .stack_pc, .next_long,
    .sreg_in, .done, .rd_we, .rd_data, .rd_hi_we, .rd_hi_data, .r1r0_we, .r1r0_data,
    .sreg_we, .sreg_data, .pc_we, .pc_data, .push_we, .push_data);
  cabe_fetch_model i_model (.core_clk, .reset_n, .r1r0_we, .r1r0_data, .push_we,
    .push_data, .r1r0_reg(m_r1r0), .stack_top(stack_pc));
  always #5 core_clk = ~core_clk;
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // offer one op, then count cycles to done; ready must stay low meanwhile
  task automatic run(input cabe_op_t op, input logic [7:0] a, b, hi, input logic nl,
                     input logic [7:0] sin, input int n);
    int cnt;
    @(posedge core_clk);
    issue_op    <= op;
    issue_valid <= 1'b1;
    rd_val      <= a;
    rr_val      <= b;
    imm_k       <= b;
    rd_hi_val   <= hi;
    next_long   <= nl;
    sreg_in     <= sin;
    @(posedge core_clk);
    issue_valid <= 1'b0;
    #1;
    cnt = 1;
    while (done !== 1'b1 && cnt < 8) begin
      chk("issue_ready", issue_ready, 32'h0);
      @(posedge core_clk);
      #1;
      cnt++;
    end
    chk("cycles", cnt, n);
  endtask
  task automatic alu(cabe_op_t op, logic [7:0] a, b, sin, res, sr, logic we);
    run(op, a, b, 8'h00, 1'b0, sin, 1);
    chk("rd_we", rd_we, we);
    if (we) chk("rd_data", rd_data, res);
    chk("sreg", sreg_we ? sreg_data : sin, sr);
  endtask
  task automatic wrd(cabe_op_t op, logic [7:0] hi, lo, k, sin, logic [15:0] res,
                     logic [7:0] sr);
    run(op, lo, k, hi, 1'b0, sin, 2);
    chk("pair_we", {rd_hi_we, rd_we}, 32'h3);
    chk("pair", {rd_hi_data, rd_data}, res);
    chk("sreg", sreg_we ? sreg_data : sin, sr);
  endtask
  task automatic mul(cabe_op_t op, logic [7:0] a, b, sin, logic [15:0] p, logic [7:0] sr);
    run(op, a, b, 8'h00, 1'b0, sin, 2);
    chk("r1r0_we", r1r0_we, 32'h1);
    chk("r1r0", r1r0_data, p);
    chk("sreg", sreg_we ? sreg_data : sin, sr);
  endtask
  // flow ops: jump target, pushed return address and status effect
  task automatic flow(cabe_op_t op, logic [7:0] a, b, logic nl, int n, logic pwe,
                      logic [PC_W-1:0] pc, logic pshwe, logic [PC_W-1:0] psh, logic [7:0] sr);
    run(op, a, b, 8'h00, nl, 8'h05, n);
    chk("pc_we", pc_we, pwe);
    if (pwe) chk("pc", pc_data, pc);
    chk("push_we", push_we, pshwe);
    if (pshwe) chk("push", push_data, psh);
    chk("sreg", sreg_we ? sreg_data : 8'h05, sr);
  endtask
  // op offered in the done cycle of the one before
  task automatic b2b();
    @(posedge core_clk);
    issue_op    <= op_add;
    issue_valid <= 1'b1;
    rd_val      <= 8'h01;
    rr_val      <= 8'h02;
    @(posedge core_clk);
    issue_op    <= op_subtract;
    #1 chk("b2b_add", rd_data, 8'h03);
    @(posedge core_clk);
    issue_valid <= 1'b0;
    #1 chk("b2b_sub", rd_data, 8'hFF);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    alu(op_add, 8'h0F, 8'h01, 8'hC0, 8'h10, 8'hE0, 1'b1);
    alu(op_add_carry, 8'h7F, 8'h00, 8'hC1, 8'h80, 8'hEC, 1'b1);
    alu(op_subtract, 8'h00, 8'h01, 8'hC0, 8'hFF, 8'hE5, 1'b1);
    alu(op_subtract_constant, 8'h80, 8'h01, 8'hC0, 8'h7F, 8'hE8, 1'b1);
    alu(op_subtract_borrow, 8'h05, 8'h05, 8'hC1, 8'hFF, 8'hE5, 1'b1);
    alu(op_subtract_borrow_constant, 8'h10, 8'h00, 8'hC1, 8'h0F, 8'hE0, 1'b1);
    alu(op_and, 8'hF0, 8'h0F, 8'hC8, 8'h00, 8'hC2, 1'b1);
    alu(op_mask_constant, 8'h80, 8'hFF, 8'hC1, 8'h80, 8'hC5, 1'b1);
    alu(op_or, 8'h01, 8'h80, 8'hC0, 8'h81, 8'hC4, 1'b1);
    alu(op_merge_constant, 8'h00, 8'h00, 8'hC0, 8'h00, 8'hC2, 1'b1);
    alu(op_xor_registers, 8'hAA, 8'hAA, 8'hC4, 8'h00, 8'hC2, 1'b1);
    alu(op_bits_set, 8'h01, 8'h02, 8'hE1, 8'h03, 8'hE1, 1'b1);
    alu(op_bits_clear, 8'hFF, 8'h0F, 8'hC0, 8'hF0, 8'hC4, 1'b1);
    alu(op_bitwise_invert, 8'h00, 8'h00, 8'hC0, 8'hFF, 8'hC5, 1'b1);
    alu(op_twos_complement_op, 8'h01, 8'h00, 8'hC0, 8'hFF, 8'hE5, 1'b1);
    alu(op_plus_one, 8'h7F, 8'h00, 8'hC0, 8'h80, 8'hCC, 1'b1);
    alu(op_minus_one, 8'h01, 8'h00, 8'hC0, 8'h00, 8'hC2, 1'b1);
    alu(op_test_value, 8'h80, 8'h00, 8'hC0, 8'h00, 8'hC4, 1'b0);
    alu(op_zero_register, 8'h55, 8'h00, 8'hCC, 8'h00, 8'hC2, 1'b1);
    alu(op_set_all_ones, 8'h12, 8'h00, 8'hEF, 8'hFF, 8'hEF, 1'b1);
    alu(op_nop, 8'h12, 8'h00, 8'hC3, 8'h00, 8'hC3, 1'b0);
    b2b();
    $display("test byte ops done");
    wrd(op_word_add_immediate, 8'hFF, 8'hFF, 8'h01, 8'hC0, 16'h0000, 8'hC3);
    wrd(op_word_subtract_immediate, 8'h80, 8'h00, 8'h01, 8'hC0, 16'h7FFF, 8'hD8);
    $display("test word ops done");
    mul(op_product_unsigned, 8'hFF, 8'hFF, 8'hC0, 16'hFE01, 8'hC1);
    mul(op_product_unsigned, 8'h00, 8'h55, 8'hC1, 16'h0000, 8'hC2);
    mul(op_product_signed, 8'hFF, 8'hFF, 8'hC3, 16'h0001, 8'hC0);
    mul(op_product_signed_by_unsigned, 8'hFF, 8'h02, 8'hC0, 16'hFFFE, 8'hC1);
    mul(op_fractional_product_unsigned, 8'h80, 8'h80, 8'hC0, 16'h8000, 8'hC0);
    mul(op_fractional_product_signed, 8'h80, 8'h80, 8'hC0, 16'h8000, 8'hC0);
    mul(op_fractional_product_mixed, 8'h80, 8'h02, 8'hC0, 16'hFE00, 8'hC1);
    @(posedge core_clk);
    #1;
    chk("model_r1r0", m_r1r0, 16'hFE00);
    $display("test multiply done");
    flow(op_relative_jump, 8'h00, 8'h00, 0, 2, 1, 22'h00_00FF, 0, 0, 8'h05);
    flow(op_indirect_jump, 8'h00, 8'h00, 0, 2, 1, 22'h00_1234, 0, 0, 8'h05);
    flow(op_direct_jump, 8'h00, 8'h00, 0, 3, 1, abs_k, 0, 0, 8'h05);
    flow(op_relative_subroutine_invoke, 8'h00, 8'h00, 0, 4, 1, 22'h00_00FF, 1, 22'h00_0101,
         8'h05);
    flow(op_indirect_subroutine_invoke, 8'h00, 8'h00, 0, 4, 1, 22'h00_1234, 1, 22'h00_0101,
         8'h05);
    flow(op_direct_subroutine_invoke, 8'h00, 8'h00, 0, 5, 1, abs_k, 1, 22'h00_0102,
         8'h05);
    flow(op_subroutine_exit, 8'h00, 8'h00, 0, 5, 1, 22'h00_0102, 0, 0, 8'h05);
    flow(op_interrupt_exit, 8'h00, 8'h00, 0, 5, 1, 22'h00_0102, 0, 0, 8'h85);
    flow(op_compare_skip_equal, 8'h33, 8'h33, 0, 2, 1, 22'h00_0102, 0, 0, 8'h05);
    flow(op_compare_skip_equal, 8'h33, 8'h33, 1, 3, 1, 22'h00_0103, 0, 0, 8'h05);
    flow(op_compare_skip_equal, 8'h33, 8'h34, 0, 1, 0, 0, 0, 0, 8'h05);
    $display("test flow done");
    print_verdict();
  end
  // hang guard, far beyond the 140 or so cycles the tests need
  initial begin
    #200_000;
    num_errors++;
    print_verdict();
  end
endmodule
